// [include/ltdc_pkg.sv]
// Purpose: shared constants and carriers for the local output drive control
// Assumes: one clock domain, ref_clk at 20 MHz
// Notes: stream counts follow the two fixed data rates
package ltdc_pkg;
  localparam int unsigned NUM_STREAMS = 32;
  localparam int unsigned LOW_STREAMS = 16;
  localparam int unsigned CHAN_FAST = 256;
  localparam int unsigned CHAN_SLOW = 128;
  localparam int unsigned CHAN_W = 8;
  localparam int unsigned IDX_W = 13;
  localparam logic [7:0] LAST_FAST = 8'hFF;
  localparam logic [7:0] LAST_SLOW = 8'h7F;
  localparam logic [1:0] BUF_DEPTH = 2'h2;

  // one serial bit slot for all 32 streams
  typedef struct packed {
    logic [31:0] data;
    logic [31:0] drive;
  } ltdc_slot_s;

  // drive control states
  typedef enum logic [2:0] {
    ST_RESET = 3'h1,
    ST_ALWAYS = 3'h2,
    ST_GATED = 3'h4
  } ltdc_state_e;
endpackage : ltdc_pkg

// [hdl/ltdc_buf.sv]
// Purpose: two-entry buffer of slot words with valid/ready on both sides
// Assumes: same clock on both sides
// Notes: read data leaves from a register
module ltdc_buf #(
  parameter int unsigned WIDTH = 64
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [WIDTH-1:0] head;
    logic [WIDTH-1:0] tail;
    logic [1:0] count;
  } ltdc_buf_s;

  ltdc_buf_s s_q;
  ltdc_buf_s s_d;
  logic push;
  logic pop;

  // honest full and empty flags
  assign in_ready = (s_q.count != ltdc_pkg::BUF_DEPTH);
  assign out_valid = (s_q.count != 2'h0);
  assign out_data = s_q.head;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // next state of the two slots
  always_comb begin
    s_d = s_q;
    if (pop) begin
      s_d.head = s_q.tail;
    end
    if (push) begin
      if ((s_q.count == 2'h0) || (pop && s_q.count == 2'h1)) begin
        s_d.head = in_data;
      end else if (pop) begin
        s_d.tail = in_data;
      end else begin
        s_d.tail = in_data;
      end
    end
    s_d.count = s_q.count + {1'b0, push} - {1'b0, pop};
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  a_buf_no_overfl: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_q.count <= ltdc_pkg::BUF_DEPTH) else $error("buffer count above depth");
endmodule : ltdc_buf

// [hdl/ltdc_drive.sv]
// What this block does
// - with the strap low, all local output streams come out of reset driven high.
// - with the strap low, after reset the outputs stay actively driven always.
// - with the strap high, all local output streams come out of reset high impedance.
// - with the strap high, drive follows the global drive pin and the per-channel bit.
// - streams 0 to 15 carry 256 channels at the fast rate or 128 at the slow rate.
// - streams 16 to 31 carry data only at the slow rate, 128 channels each.
// - at the fast rate streams 16 to 31 carry no data and sit high or high impedance per strap.
// - while the global drive pin is low, all outputs sit high or high impedance per strap.
// - while the global drive pin is high, outputs are enabled, with the strap high subject to per-channel bits.
// - during reset the outputs sit high or high impedance per strap.
//
// Purpose: output drive control of the 32 local serial TDM streams
// Assumes: upstream supplies one slot word per bit time with per-stream channel bits
// Notes: strap and drive pin are asynchronous and pass two flip-flops first
module ltdc_drive #(
  parameter int unsigned STREAMS = ltdc_pkg::NUM_STREAMS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic local_reset_state_strap,
  input wire logic global_output_drive_pin,
  input wire logic fast_rate,
  input wire logic slot_valid,
  output logic slot_ready,
  input wire logic [STREAMS-1:0] slot_data,
  input wire logic [STREAMS-1:0] per_channel_local_drive_bit,
  input wire logic [ltdc_pkg::CHAN_W-1:0] slot_channel,
  output logic [STREAMS-1:0] local_serial_out_streams_o,
  output logic [STREAMS-1:0] local_serial_out_streams_oe,
  output logic out_tick,
  output logic strap_latched
);
  if (STREAMS != ltdc_pkg::NUM_STREAMS) begin : g_bad_streams
    $error("ltdc_drive serves exactly 32 streams");
  end

  typedef struct packed {
    logic [1:0] strap_sync;
    logic [1:0] drive_pin_sync;
    ltdc_pkg::ltdc_state_e state;
    logic strap;
    logic [STREAMS-1:0] out_o;
    logic [STREAMS-1:0] out_oe;
    logic tick;
    logic [ltdc_pkg::CHAN_W-1:0] chan;
  } ltdc_drive_s;

  ltdc_drive_s s_q;
  ltdc_drive_s s_d;
  ltdc_pkg::ltdc_slot_s buf_in;
  ltdc_pkg::ltdc_slot_s buf_out;
  logic buf_valid;
  logic [ltdc_pkg::CHAN_W-1:0] chan_out;
  logic drive_pin;

  // stream carries data at this rate
  function automatic logic stream_live(input int unsigned idx, input logic fast);
    return !(fast && idx >= ltdc_pkg::LOW_STREAMS);
  endfunction : stream_live

  // channel number in range for this rate
  function automatic logic chan_ok(input logic [7:0] ch, input logic fast);
    return fast ? (ch <= ltdc_pkg::LAST_FAST) : (ch <= ltdc_pkg::LAST_SLOW);
  endfunction : chan_ok

  assign buf_in.data = slot_data;
  assign buf_in.drive = per_channel_local_drive_bit;
  assign drive_pin = s_q.drive_pin_sync[1];
  assign chan_out = s_q.chan;

  // slot buffer between upstream and the pins
  ltdc_buf #(
    .WIDTH($bits(ltdc_pkg::ltdc_slot_s))
  ) u_buf (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(slot_valid),
    .in_ready(slot_ready),
    .in_data(buf_in),
    .out_valid(buf_valid),
    .out_ready(1'b1),
    .out_data(buf_out)
  );

  // next state: synchronisers, state machine, pin drive
  always_comb begin
    s_d = s_q;
    s_d.strap_sync = {s_q.strap_sync[0], local_reset_state_strap};
    s_d.drive_pin_sync = {s_q.drive_pin_sync[0], global_output_drive_pin};
    s_d.tick = 1'b0;
    // channel number travels one stage with the word taken, to match the buffer head
    if (slot_valid && slot_ready) begin
      s_d.chan = slot_channel;
    end
    case (s_q.state)
      ltdc_pkg::ST_RESET: begin
        // strap caught after release of reset
        s_d.strap = s_q.strap_sync[1];
        s_d.state = s_q.strap_sync[1] ? ltdc_pkg::ST_GATED : ltdc_pkg::ST_ALWAYS;
        s_d.out_o = {STREAMS{1'b1}};
        s_d.out_oe = s_q.strap_sync[1] ? '0 : {STREAMS{1'b1}};
      end
      ltdc_pkg::ST_ALWAYS, ltdc_pkg::ST_GATED: begin
        if (buf_valid) begin
          s_d.tick = 1'b1;
          for (int unsigned i = 0; i < STREAMS; i++) begin
            if (!drive_pin || !stream_live(i, fast_rate) || !chan_ok(chan_out, fast_rate)) begin
              s_d.out_o[i] = 1'b1;
              s_d.out_oe[i] = !s_q.strap;
            end else if (s_q.state == ltdc_pkg::ST_ALWAYS) begin
              s_d.out_o[i] = buf_out.data[i];
              s_d.out_oe[i] = 1'b1;
            end else begin
              s_d.out_o[i] = buf_out.drive[i] ? buf_out.data[i] : 1'b1;
              s_d.out_oe[i] = buf_out.drive[i];
            end
          end
        end else if (!drive_pin) begin
          s_d.out_o = {STREAMS{1'b1}};
          s_d.out_oe = s_q.strap ? '0 : {STREAMS{1'b1}};
        end
      end
      default: begin
        s_d.state = ltdc_pkg::ST_RESET;
      end
    endcase
  end

  // state register; during reset streams sit high, driven or released per strap
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= '0;
      // synchronisers keep running so the strap level is known while reset is held
      s_q.strap_sync <= s_d.strap_sync;
      s_q.drive_pin_sync <= s_d.drive_pin_sync;
      s_q.state <= ltdc_pkg::ST_RESET;
      s_q.out_o <= {STREAMS{1'b1}};
      s_q.out_oe <= {STREAMS{!s_q.strap_sync[1]}};
    end else begin
      s_q <= s_d;
    end
  end

  assign local_serial_out_streams_o = s_q.out_o;
  assign local_serial_out_streams_oe = s_q.out_oe;
  assign out_tick = s_q.tick;
  assign strap_latched = s_q.strap;

  // strap low: once out of reset every stream stays driven
  a_strap_low_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_q.state == ltdc_pkg::ST_ALWAYS) |-> (local_serial_out_streams_oe == '1))
    else $error("strap low stream not driven");

  // drive pin low: every stream at the idle high level
  a_drv_low_safe: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!drive_pin && s_q.state != ltdc_pkg::ST_RESET) |=> (local_serial_out_streams_o == '1))
    else $error("outputs not high while drive pin low");

  // drive pin low with strap high: every stream released
  a_drv_low_z: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!drive_pin && s_q.strap && s_q.state == ltdc_pkg::ST_GATED)
    |=> (local_serial_out_streams_oe == '0))
    else $error("outputs driven while pin low and strap high");

  // drive pin high with strap low: slot data reach the lower streams
  a_drv_high_data: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (drive_pin && s_q.state == ltdc_pkg::ST_ALWAYS && buf_valid
     && chan_ok(chan_out, fast_rate))
    |=> (local_serial_out_streams_o[ltdc_pkg::LOW_STREAMS-1:0]
         == $past(buf_out.data[ltdc_pkg::LOW_STREAMS-1:0])))
    else $error("slot data not passed with drive pin high");

  // fast rate: upper streams carry no data
  a_fast_upper_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (fast_rate && s_q.state != ltdc_pkg::ST_RESET && buf_valid) |=>
    (local_serial_out_streams_o[STREAMS-1:ltdc_pkg::LOW_STREAMS] == '1))
    else $error("upper streams carry data at fast rate");

  // fast rate: upper streams driven or released as the strap selects
  a_fast_upper_oe: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (fast_rate && s_q.state != ltdc_pkg::ST_RESET && buf_valid) |=>
    (local_serial_out_streams_oe[STREAMS-1:ltdc_pkg::LOW_STREAMS]
     == {(STREAMS-ltdc_pkg::LOW_STREAMS){!s_q.strap}}))
    else $error("upper streams not at strap level at fast rate");

  // streams leave reset at the high level
  a_reset_exit_level: assert property (@(posedge ref_clk)
    (!$past(rst_n) && rst_n) |-> (local_serial_out_streams_o == '1))
    else $error("outputs not high after reset");

  // strap caught on the first edge after reset picks the starting drive
  a_init_strap_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_q.state == ltdc_pkg::ST_RESET && s_q.strap_sync[1]) |=>
    (local_serial_out_streams_oe == '0 && s_q.state == ltdc_pkg::ST_GATED))
    else $error("strap high did not start high impedance");

  a_init_strap_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_q.state == ltdc_pkg::ST_RESET && !s_q.strap_sync[1]) |=>
    (local_serial_out_streams_oe == '1 && local_serial_out_streams_o == '1))
    else $error("strap low did not start driven high");

  // strap high, slow rate: each slot follows its own drive bit
  a_chan_bit_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_q.state == ltdc_pkg::ST_GATED && drive_pin && buf_valid && !fast_rate
     && chan_ok(chan_out, fast_rate)) |=> (local_serial_out_streams_oe == $past(buf_out.drive)))
    else $error("per-channel bit not applied");

  // a released slot still shows the high level on its data line
  a_gated_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_q.state == ltdc_pkg::ST_GATED && drive_pin && buf_valid && !fast_rate
     && chan_ok(chan_out, fast_rate))
    |=> (local_serial_out_streams_o == ($past(buf_out.data) | ~$past(buf_out.drive))))
    else $error("gated slot level wrong");

  // slow rate: channels past the last slow channel carry no data
  a_slow_chan_range: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_q.state == ltdc_pkg::ST_ALWAYS && drive_pin && buf_valid && !fast_rate
     && chan_out > ltdc_pkg::LAST_SLOW) |=> (local_serial_out_streams_o == '1))
    else $error("slow rate channel above 127 carried data");

  // main scenarios
  c_gated_run: cover property (@(posedge ref_clk) s_q.state == ltdc_pkg::ST_GATED && out_tick);
  c_always_run: cover property (@(posedge ref_clk) s_q.state == ltdc_pkg::ST_ALWAYS && out_tick);
  c_drive_drop: cover property (@(posedge ref_clk)
    $fell(drive_pin) && s_q.state != ltdc_pkg::ST_RESET);
  c_strap_high_init: cover property (@(posedge ref_clk)
    rst_n && s_q.state == ltdc_pkg::ST_RESET && s_q.strap_sync[1]);
  c_buf_full: cover property (@(posedge ref_clk) !slot_ready);
endmodule : ltdc_drive

// [verif/ltdc_sink.sv]
// Purpose: downstream receiver model of the 32 local output streams
// Assumes: the stream lines carry no pull resistor
// Notes: an undriven line shows a level that flips every cycle
module ltdc_sink (
  input wire logic ref_clk,
  input wire logic [31:0] pin_o,
  input wire logic [31:0] pin_oe,
  output logic [31:0] line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] last_q = 32'hFFFFFFFF;
  // resolve each line from its enable, released lines never hold a stale level
  always_comb line = (pin_o & pin_oe) | (~last_q & ~pin_oe);
  // remember the level seen on each line
  always_ff @(posedge ref_clk) last_q <= line;
endmodule : ltdc_sink

// [verif/tb_top.sv]
// Purpose: self-checking bench of the local output drive control
// Assumes: 50 ns clock, no stall at the output pins
// Notes: expected pin words are queued at take and popped on out_tick
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_n, strap, pin, fast, valid, ready, tick, latched;
  logic [31:0] sdata, sbits, o, oe, line;
  logic [7:0] chan;
  logic [63:0] expq[$];
  logic [63:0] exp_w;
  int errors, n_tests, cyc, seed;
  ltdc_drive dut (.ref_clk(ref_clk), .rst_n(rst_n), .local_reset_state_strap(strap),
    .global_output_drive_pin(pin), .fast_rate(fast), .slot_valid(valid), .slot_ready(ready),
    .slot_data(sdata), .per_channel_local_drive_bit(sbits), .slot_channel(chan),
    .local_serial_out_streams_o(o), .local_serial_out_streams_oe(oe), .out_tick(tick),
    .strap_latched(latched));
  ltdc_sink sink (.ref_clk(ref_clk), .pin_o(o), .pin_oe(oe), .line(line));
  // expected pins from strap, drive pin, rate, channel, data and drive bits
  function automatic logic [63:0] expv(logic s, logic p, logic f, logic [7:0] c,
                                       logic [31:0] d, logic [31:0] b);
    logic [31:0] eo, eoe;
    for (int i = 0; i < 32; i++) begin
      if (!p || (f && i >= 16) || (!f && c > 8'h7F)) begin
        eo[i] = 1'b1;
        eoe[i] = !s;
      end else begin
        eo[i] = (s && !b[i]) ? 1'b1 : d[i];
        eoe[i] = s ? b[i] : 1'b1;
      end
    end
    return {eo, eoe};
  endfunction : expv
  task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic test_done();
    if (expq.size() != 0) errors++;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic cycles(int n);
    repeat (n) @(posedge ref_clk);
  endtask : cycles
  // offer one slot word, optionally followed by an idle cycle
  task automatic send(logic [7:0] c, bit gap);
    logic [31:0] d, b;
    d = $random(seed);
    b = $random(seed);
    sdata <= d;
    sbits <= b;
    chan <= c;
    valid <= 1'b1;
    expq.push_back(expv(strap, pin, fast, c, d, b));
    @(posedge ref_clk);
    if (gap) begin
      valid <= 1'b0;
      @(posedge ref_clk);
    end
  endtask : send
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // pop the oldest note whenever pins update from a word
  always @(negedge ref_clk) if (tick === 1'b1) begin
    if (expq.size() == 0) check("tick", 64'h1, 64'h0);
    else begin
      exp_w = expq.pop_front();
      check("pins", {o, oe}, exp_w);
      check("line", {32'h0, line & oe}, {32'h0, exp_w[63:32] & oe});
    end
  end
  // cut a hang short
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      test_done();
    end
  end
  initial begin
    seed = 69;
    {rst_n, strap, pin, fast, valid, sdata, sbits, chan} = '0;
    pin = 1'b1;
    for (int s = 0; s < 2; s++) begin
      if (s != 0) begin
        strap <= 1'b1; // strap settles through its synchroniser before reset
        cycles(2);
      end
      rst_n <= 1'b0;
      fast <= 1'b0;
      cycles(3);
      rst_n <= 1'b1;
      @(negedge ref_clk);
      check("reset pins", {o, oe}, {32'hFFFFFFFF, s[0] ? 32'h0 : 32'hFFFFFFFF});
      cycles(2);
      @(negedge ref_clk);
      check("latched", {63'h0, latched}, {63'h0, s[0]});
      check("init pins", {o, oe}, {32'hFFFFFFFF, s[0] ? 32'h0 : 32'hFFFFFFFF});
      for (int f = 0; f < 2; f++) begin
        @(posedge ref_clk);
        fast <= f[0];
        cycles(2);
        for (int k = 0; k < 6; k++) send(8'($random(seed)), 1'b1);
        send(8'h7F, 1'b1);
        send(8'h80, 1'b1);
        for (int k = 0; k < 4; k++) send(8'h10, k == 3);
        cycles(4);
        pin <= 1'b0;
        cycles(6);
        @(negedge ref_clk);
        check("forced pins", {o, oe}, {32'hFFFFFFFF, s[0] ? 32'h0 : 32'hFFFFFFFF});
        @(posedge ref_clk);
        send(8'h05, 1'b1);
        cycles(4);
        pin <= 1'b1;
        cycles(6);
      end
    end
    test_done();
  end
endmodule : tb_top
